// file: shared/tspc_consts.svh
/*
  Register offsets, field positions, reset values and timing counts for the
  transmitter synthesizer and amplifier configuration bank.
  Assumes the includer runs on the 25 MHz reference clock.
*/
`ifndef TSPC_CONSTS_SVH
`define TSPC_CONSTS_SVH

`define TSPC_ADDR_W           7
`define TSPC_OFF_MODE         7'h01
`define TSPC_OFF_RATE_HIGH    7'h03
`define TSPC_OFF_RATE_LOW     7'h04
`define TSPC_OFF_DEV_HIGH     7'h05
`define TSPC_OFF_DEV_LOW      7'h06
`define TSPC_OFF_CAR_HIGH     7'h07
`define TSPC_OFF_CAR_MIDDLE   7'h08
`define TSPC_OFF_CAR_LOW      7'h09
`define TSPC_OFF_CAL_STATUS   7'h0a
`define TSPC_OFF_PA_CONFIG    7'h11
`define TSPC_OFF_OCP_TRIM     7'h13

`define TSPC_CAL_START_BIT    2
`define TSPC_CAL_OK_BIT       3
`define TSPC_CAL_DONE_BIT     4
`define TSPC_PA_SEL_LSB       5
`define TSPC_MODE_CUR_LSB     3

`define TSPC_RST_CAR_WORD     24'he4c000
`define TSPC_RST_DEV          14'h0052
`define TSPC_RST_RATE         16'h1a0b
`define TSPC_RST_PA_SEL       2'h1
`define TSPC_RST_POW          5'h1f
`define TSPC_RST_OCP          4'ha
`define TSPC_RST_MODE         3'h1

`define TSPC_CLK_KHZ          25000
`define TSPC_XOSC_KHZ         32000
`define TSPC_CAL_TIME_US      500
`define TSPC_CAL_CYCLES       ((`TSPC_CAL_TIME_US * `TSPC_CLK_KHZ) / 1000)
`define TSPC_MODE_STEP_US     100
`define TSPC_MODE_STEP_CYCLES ((`TSPC_MODE_STEP_US * `TSPC_CLK_KHZ) / 1000)

// Band edges in MHz, turned into carrier words as MHz * 2^19 / fxosc
// Worked in 64 bits: the product overflows a plain 32-bit integer
`define TSPC_MHZ_TO_WORD(m)   ((64'd524288 * (m) * 1000) / `TSPC_XOSC_KHZ)
`define TSPC_BAND_LO_MIN      `TSPC_MHZ_TO_WORD(290)
`define TSPC_BAND_LO_MAX      `TSPC_MHZ_TO_WORD(340)
`define TSPC_BAND_MID_MIN     `TSPC_MHZ_TO_WORD(431)
`define TSPC_BAND_MID_MAX     `TSPC_MHZ_TO_WORD(510)
`define TSPC_BAND_HI_MIN      `TSPC_MHZ_TO_WORD(862)
`define TSPC_BAND_HI_MAX      `TSPC_MHZ_TO_WORD(1020)

`define TSPC_LPA_MAX_POW      5'h0f
`define TSPC_SINGLE_BASE_DBM  6'h12
`define TSPC_DUAL_BASE_DBM    6'h0d
`define TSPC_LF_WIDE_RATE     16'h0200
`define TSPC_LF_WIDE_DEV      14'h0400

`endif

// file: shared/tspc_pkg.sv
/*
  Types of the transmitter synthesizer and amplifier configuration bank.
  Assumes tspc_consts.svh is on the include path.
*/
`include "tspc_consts.svh"

package tspc_pkg;

  typedef enum logic [1:0] {
    TSPC_CAL_IDLE = 2'b01,
    TSPC_CAL_RUN  = 2'b10
  } tspc_cal_state_t;

  typedef enum logic [1:0] {
    TSPC_BAND_NONE = 2'h0,
    TSPC_BAND_LOW  = 2'h1,
    TSPC_BAND_MID  = 2'h2,
    TSPC_BAND_HIGH = 2'h3
  } tspc_band_t;

  typedef struct packed {
    logic                      wr;
    logic                      rd;
    logic [`TSPC_ADDR_W-1:0]   addr;
    logic [7:0]                wdata;
  } tspc_reg_req_t;

  typedef struct packed {
    logic                      first_amplifier;
    logic                      second_amplifier;
    logic                      low_power_stage;
    logic                      high_power_stage;
    logic signed [5:0]         power_dbm;
  } tspc_pa_ctrl_t;

  typedef struct packed {
    logic [23:0]               carrier_freq_word;
    tspc_band_t                band;
    logic [13:0]               deviation_coeff;
    logic [15:0]               rate_divisor;
    logic                      loop_filter_wide;
  } tspc_synth_cfg_t;

  typedef struct packed {
    logic [7:0]                carrier_word_high;
    logic [7:0]                carrier_word_middle;
    logic [5:0]                deviation_high;
    logic [7:0]                rate_divisor_high;
    tspc_synth_cfg_t           synth;
    logic [15:0]               rate_cnt;
    logic                      bit_tick;
    logic [1:0]                amp_path_select;
    logic [4:0]                out_level;
    logic [3:0]                ocp_trim;
    tspc_pa_ctrl_t             pa;
    logic [2:0]                mode_target;
    logic [2:0]                mode_current;
    logic [11:0]               mode_cnt;
    tspc_cal_state_t           cal_state;
    logic [19:0]               cal_cnt;
    logic                      synth_cal_complete;
    logic                      synth_cal_success;
    logic                      lock_s1;
    logic                      lock_s2;
    logic [7:0]                rdata;
  } tspc_state_t;

endpackage : tspc_pkg

// file: hw/tspc_config.sv
/*
  Configuration bank for the transmitter synthesizer, modulator rate and
  power amplifier: byte registers, band choice, bit-rate strobe, calibration
  sequencing and operating-mode stepping.
  Assumes an SPI slave in front of it issuing one-cycle byte requests on the
  reference clock, and an analog lock indication from outside this domain.
*/
`timescale 1ns/1ps
`include "tspc_consts.svh"

module tspc_config #(
  parameter int unsigned CAL_CYCLES = `TSPC_CAL_CYCLES
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_reset_n,
  input  wire tspc_pkg::tspc_reg_req_t   i_reg_req,
  output logic [7:0]                     o_reg_rdata,
  input  wire logic                      i_synth_locked,
  output tspc_pkg::tspc_synth_cfg_t      o_synth_cfg,
  output logic                           o_bit_tick,
  output logic                           o_cal_running,
  output tspc_pkg::tspc_pa_ctrl_t        o_pa_ctrl,
  output logic [3:0]                     o_ocp_trim,
  output logic [2:0]                     o_mode_current
);

  tspc_pkg::tspc_state_t st_reg;
  tspc_pkg::tspc_state_t st_next;

  function automatic tspc_pkg::tspc_band_t band_of(input logic [23:0] word);
    if (word >= 24'(`TSPC_BAND_LO_MIN) && word <= 24'(`TSPC_BAND_LO_MAX)) begin
      band_of = tspc_pkg::TSPC_BAND_LOW;
    end else if (word >= 24'(`TSPC_BAND_MID_MIN) && word <= 24'(`TSPC_BAND_MID_MAX)) begin
      band_of = tspc_pkg::TSPC_BAND_MID;
    end else if (word >= 24'(`TSPC_BAND_HI_MIN) && word <= 24'(`TSPC_BAND_HI_MAX)) begin
      band_of = tspc_pkg::TSPC_BAND_HIGH;
    end else begin
      band_of = tspc_pkg::TSPC_BAND_NONE;
    end
  endfunction : band_of

  function automatic tspc_pkg::tspc_pa_ctrl_t pa_of(input logic [1:0] sel,
                                                    input logic [4:0] lvl);
    pa_of = '0;
    unique case (sel)
      2'h1: begin
        pa_of.first_amplifier  = 1'b1;
        pa_of.low_power_stage  = (lvl <= `TSPC_LPA_MAX_POW);
        pa_of.high_power_stage = (lvl > `TSPC_LPA_MAX_POW);
        pa_of.power_dbm        = $signed({1'b0, lvl}) - $signed(`TSPC_SINGLE_BASE_DBM);
      end
      2'h2: begin
        pa_of.second_amplifier = 1'b1;
        pa_of.power_dbm        = $signed({1'b0, lvl}) - $signed(`TSPC_SINGLE_BASE_DBM);
      end
      2'h3: begin
        pa_of.first_amplifier  = 1'b1;
        pa_of.high_power_stage = 1'b1;
        pa_of.second_amplifier = 1'b1;
        pa_of.power_dbm        = $signed({1'b0, lvl}) - $signed(`TSPC_DUAL_BASE_DBM);
      end
      default: begin
        // Code 00 is invalid: both paths stay off rather than guessing
        pa_of = '0;
      end
    endcase
  endfunction : pa_of

  logic wr_hit;
  logic rd_hit;

  always_comb begin
    st_next          = st_reg;
    wr_hit           = i_reg_req.wr;
    rd_hit           = i_reg_req.rd;
    st_next.bit_tick = 1'b0;

    // Only the second stage is read; the lock level is asynchronous
    st_next.lock_s1 = i_synth_locked;
    st_next.lock_s2 = st_reg.lock_s1;

    // Register writes; multi-byte words commit on their low byte
    if (wr_hit) begin
      unique case (i_reg_req.addr)
        `TSPC_OFF_CAR_HIGH:   st_next.carrier_word_high   = i_reg_req.wdata;
        `TSPC_OFF_CAR_MIDDLE: st_next.carrier_word_middle = i_reg_req.wdata;
        `TSPC_OFF_CAR_LOW: begin
          st_next.synth.carrier_freq_word = {st_reg.carrier_word_high,
                                             st_reg.carrier_word_middle,
                                             i_reg_req.wdata};
        end
        `TSPC_OFF_DEV_HIGH:   st_next.deviation_high = i_reg_req.wdata[5:0];
        `TSPC_OFF_DEV_LOW: begin
          st_next.synth.deviation_coeff = {st_reg.deviation_high, i_reg_req.wdata};
        end
        `TSPC_OFF_RATE_HIGH:  st_next.rate_divisor_high = i_reg_req.wdata;
        `TSPC_OFF_RATE_LOW: begin
          st_next.synth.rate_divisor = {st_reg.rate_divisor_high, i_reg_req.wdata};
        end
        `TSPC_OFF_PA_CONFIG: begin
          st_next.amp_path_select = i_reg_req.wdata[`TSPC_PA_SEL_LSB +: 2];
          st_next.out_level       = i_reg_req.wdata[4:0];
        end
        `TSPC_OFF_OCP_TRIM:   st_next.ocp_trim = i_reg_req.wdata[3:0];
        `TSPC_OFF_MODE: begin
          // Codes above transmit are not modes; the target is kept
          if (i_reg_req.wdata[2:0] <= 3'h3) begin
            st_next.mode_target = i_reg_req.wdata[2:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Derived settings follow the committed words one cycle later
    st_next.synth.band             = band_of(st_reg.synth.carrier_freq_word);
    st_next.synth.loop_filter_wide = (st_reg.synth.rate_divisor < `TSPC_LF_WIDE_RATE) ||
                                     (st_reg.synth.deviation_coeff >= `TSPC_LF_WIDE_DEV);
    st_next.pa                     = pa_of(st_reg.amp_path_select, st_reg.out_level);

    // Bit-rate strobe; a divisor of zero or one strobes every cycle
    if (st_reg.rate_cnt + 16'h0001 >= st_reg.synth.rate_divisor) begin
      st_next.rate_cnt = 16'h0000;
      st_next.bit_tick = 1'b1;
    end else begin
      st_next.rate_cnt = st_reg.rate_cnt + 16'h0001;
    end

    // Calibration; a start while running restarts the full period
    unique case (st_reg.cal_state)
      tspc_pkg::TSPC_CAL_IDLE: begin
        st_next.cal_cnt = '0;
      end
      tspc_pkg::TSPC_CAL_RUN: begin
        if (st_reg.cal_cnt + 20'h00001 >= 20'(CAL_CYCLES)) begin
          st_next.cal_state          = tspc_pkg::TSPC_CAL_IDLE;
          st_next.synth_cal_complete = 1'b1;
          st_next.synth_cal_success  = st_reg.lock_s2;
        end else begin
          st_next.cal_cnt = st_reg.cal_cnt + 20'h00001;
        end
      end
    endcase
    if (wr_hit && i_reg_req.addr == `TSPC_OFF_CAL_STATUS &&
        i_reg_req.wdata[`TSPC_CAL_START_BIT]) begin
      st_next.cal_state          = tspc_pkg::TSPC_CAL_RUN;
      st_next.cal_cnt            = '0;
      st_next.synth_cal_complete = 1'b0;
      st_next.synth_cal_success  = 1'b0;
    end

    // Walk one mode at a time so each block is up before the next starts
    if (st_reg.mode_current == st_reg.mode_target) begin
      st_next.mode_cnt = '0;
    end else if (st_reg.mode_cnt + 12'h001 >= 12'(`TSPC_MODE_STEP_CYCLES)) begin
      st_next.mode_cnt     = '0;
      st_next.mode_current = (st_reg.mode_target > st_reg.mode_current) ?
                             st_reg.mode_current + 3'h1 :
                             st_reg.mode_current - 3'h1;
    end else begin
      st_next.mode_cnt = st_reg.mode_cnt + 12'h001;
    end

    // Read data answers one cycle after the request
    st_next.rdata = 8'h00;
    if (rd_hit) begin
      unique case (i_reg_req.addr)
        `TSPC_OFF_CAR_HIGH:   st_next.rdata = st_reg.carrier_word_high;
        `TSPC_OFF_CAR_MIDDLE: st_next.rdata = st_reg.carrier_word_middle;
        `TSPC_OFF_CAR_LOW:    st_next.rdata = st_reg.synth.carrier_freq_word[7:0];
        `TSPC_OFF_DEV_HIGH:   st_next.rdata = {2'h0, st_reg.deviation_high};
        `TSPC_OFF_DEV_LOW:    st_next.rdata = st_reg.synth.deviation_coeff[7:0];
        `TSPC_OFF_RATE_HIGH:  st_next.rdata = st_reg.rate_divisor_high;
        `TSPC_OFF_RATE_LOW:   st_next.rdata = st_reg.synth.rate_divisor[7:0];
        `TSPC_OFF_PA_CONFIG:  st_next.rdata = {1'b0, st_reg.amp_path_select, st_reg.out_level};
        `TSPC_OFF_OCP_TRIM:   st_next.rdata = {4'h0, st_reg.ocp_trim};
        `TSPC_OFF_MODE: begin
          st_next.rdata = {2'h0, st_reg.mode_current, st_reg.mode_target};
        end
        `TSPC_OFF_CAL_STATUS: begin
          st_next.rdata[`TSPC_CAL_DONE_BIT] = st_reg.synth_cal_complete;
          st_next.rdata[`TSPC_CAL_OK_BIT]   = st_reg.synth_cal_success;
        end
        default: st_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st_reg                          <= '0;
      st_reg.synth.carrier_freq_word  <= `TSPC_RST_CAR_WORD;
      st_reg.carrier_word_high        <= 8'(`TSPC_RST_CAR_WORD >> 16);
      st_reg.carrier_word_middle      <= 8'(`TSPC_RST_CAR_WORD >> 8);
      st_reg.synth.band               <= tspc_pkg::TSPC_BAND_NONE;
      st_reg.synth.deviation_coeff    <= `TSPC_RST_DEV;
      st_reg.deviation_high           <= 6'(`TSPC_RST_DEV >> 8);
      st_reg.synth.rate_divisor       <= `TSPC_RST_RATE;
      st_reg.rate_divisor_high        <= 8'(`TSPC_RST_RATE >> 8);
      st_reg.amp_path_select          <= `TSPC_RST_PA_SEL;
      st_reg.out_level                <= `TSPC_RST_POW;
      st_reg.ocp_trim                 <= `TSPC_RST_OCP;
      st_reg.mode_target              <= `TSPC_RST_MODE;
      st_reg.cal_state                <= tspc_pkg::TSPC_CAL_RUN;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_reg_rdata    = st_reg.rdata;
  assign o_synth_cfg    = st_reg.synth;
  assign o_bit_tick     = st_reg.bit_tick;
  assign o_cal_running  = (st_reg.cal_state == tspc_pkg::TSPC_CAL_RUN);
  assign o_pa_ctrl      = st_reg.pa;
  // Overcurrent clamping happens in the analog path; only the trim leaves here
  assign o_ocp_trim     = st_reg.ocp_trim;
  assign o_mode_current = st_reg.mode_current;

endmodule : tspc_config

// file: verification/tspc_config_properties.sv
/* Port checker for the synthesizer and amplifier configuration bank.
   Assumes it is bound onto tspc_config and sees only that module's ports. */
`timescale 1ns/1ps
`include "tspc_consts.svh"
module tspc_chk #(
  parameter int unsigned CAL_CYCLES = 50
) (
  input wire logic                      i_clk,
  input wire logic                      i_reset_n,
  input wire tspc_pkg::tspc_reg_req_t   i_reg_req,
  input wire tspc_pkg::tspc_synth_cfg_t o_synth_cfg,
  input wire logic                      o_bit_tick,
  input wire logic                      o_cal_running,
  input wire tspc_pkg::tspc_pa_ctrl_t   o_pa_ctrl,
  input wire logic [3:0]                o_ocp_trim,
  input wire logic [2:0]                o_mode_current
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic        start;
  logic        wr_car;
  logic [19:0] run_cnt_reg;
  assign start  = i_reg_req.wr && i_reg_req.addr == 7'h0a && i_reg_req.wdata[2];
  assign wr_car = i_reg_req.wr && i_reg_req.addr == 7'h09;
  // Reset counts as a start, so the power-up run is timed like a requested one
  always_ff @(posedge i_clk) begin
    run_cnt_reg <= (!i_reset_n || start || !o_cal_running) ? 20'h0 : run_cnt_reg + 20'h1;
  end
  function automatic tspc_pkg::tspc_band_t band_of(input logic [23:0] w);
    return (w >= `TSPC_BAND_LO_MIN && w <= `TSPC_BAND_LO_MAX) ? tspc_pkg::TSPC_BAND_LOW :
           (w >= `TSPC_BAND_MID_MIN && w <= `TSPC_BAND_MID_MAX) ? tspc_pkg::TSPC_BAND_MID :
           (w >= `TSPC_BAND_HI_MIN && w <= `TSPC_BAND_HI_MAX) ? tspc_pkg::TSPC_BAND_HIGH :
           tspc_pkg::TSPC_BAND_NONE;
  endfunction : band_of
  function automatic tspc_pkg::tspc_pa_ctrl_t exp_pa(input logic [6:0] w);
    tspc_pkg::tspc_pa_ctrl_t p;
    p = '0;
    p.first_amplifier  = w[5];
    p.second_amplifier = w[6];
    p.low_power_stage  = (w[6:5] == 2'h1) && (w[4:0] <= 5'h0f);
    p.high_power_stage = w[5] && !p.low_power_stage;
    if (w[6:5] != 2'h0) begin
      p.power_dbm = $signed({1'b0, w[4:0]}) - ((w[6:5] == 2'h3) ? 6'sh0d : 6'sh12);
    end
    return p;
  endfunction : exp_pa
  a_cal_start_runs: assert property (start |=> o_cal_running)
    else $error("calibration not running after start write");
  a_cal_run_length: assert property ($fell(o_cal_running) |-> run_cnt_reg == 20'(CAL_CYCLES))
    else $error("calibration length wrong");
  a_carrier_low_byte: assert property (wr_car |=> o_synth_cfg.carrier_freq_word[7:0] == $past(i_reg_req.wdata))
    else $error("carrier low byte not applied");
  a_carrier_held: assert property (!wr_car |=> $stable(o_synth_cfg.carrier_freq_word))
    else $error("carrier word changed without low byte write");
  a_band_follows: assert property (1'b1 |=> o_synth_cfg.band == band_of($past(o_synth_cfg.carrier_freq_word)))
    else $error("band does not match carrier word");
  a_pa_mode_map: assert property (i_reg_req.wr && i_reg_req.addr == 7'h11 |-> ##2 o_pa_ctrl == exp_pa($past(i_reg_req.wdata[6:0], 2)))
    else $error("amplifier control wrong after config write");
  a_trim_applied: assert property (i_reg_req.wr && i_reg_req.addr == 7'h13 |=> o_ocp_trim == $past(i_reg_req.wdata[3:0]))
    else $error("trim field not applied");
  a_mode_one_step: assert property ($changed(o_mode_current) |-> o_mode_current == $past(o_mode_current) + 3'h1 || o_mode_current == $past(o_mode_current) - 3'h1)
    else $error("mode moved more than one step");
  a_tick_single: assert property (o_bit_tick && o_synth_cfg.rate_divisor > 16'h0001 |=> !o_bit_tick)
    else $error("bit tick longer than one cycle");
  c_cal_done: cover property ($fell(o_cal_running));
  c_dual_pa: cover property (o_pa_ctrl.first_amplifier && o_pa_ctrl.second_amplifier);
  c_tick: cover property (o_bit_tick);
endmodule : tspc_chk
bind tspc_config tspc_chk #(.CAL_CYCLES(CAL_CYCLES)) i_tspc_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_reg_req(i_reg_req), .o_synth_cfg(o_synth_cfg), .o_bit_tick(o_bit_tick),
  .o_cal_running(o_cal_running), .o_pa_ctrl(o_pa_ctrl), .o_ocp_trim(o_ocp_trim),
  .o_mode_current(o_mode_current));

// file: verification/tspc_host.sv
/* Host model issuing byte register requests to the configuration bank.
   Assumes requests are launched at the falling edge of the reference clock. */
`timescale 1ns/1ps
module tspc_host (
  input  wire logic               i_clk,
  input  wire logic [7:0]         i_reg_rdata,
  output tspc_pkg::tspc_reg_req_t o_reg_req
);
  initial o_reg_req = '0;
  // Released address and data lines show inverted garbage, never the last value
  task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_reg_req = '{1'b1, 1'b0, a, d};
    @(negedge i_clk);
    o_reg_req = '{1'b0, 1'b0, ~a, ~d};
  endtask : write_reg
  task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_reg_req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge i_clk);
    d = i_reg_rdata;
    o_reg_req = '{1'b0, 1'b0, ~a, 8'hff};
  endtask : read_reg
  task automatic set_rate(input logic [15:0] div, input logic ook);
    logic [15:0] v;
    v = (ook && div < 16'h03d3) ? 16'h03d3 : div;
    write_reg(7'h03, v[15:8]);
    write_reg(7'h04, v[7:0]);
  endtask : set_rate
  task automatic set_full_power_trim();
    write_reg(7'h13, 8'h0c);
  endtask : set_full_power_trim
endmodule : tspc_host

// file: verification/tb_top.sv
/* Self-checking bench for the configuration bank.
   Assumes the checker is bound in and calibration is shortened to 50 cycles. */
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned CAL = 50;
  logic                      i_clk, i_reset_n, i_synth_locked, tick, cal_run;
  tspc_pkg::tspc_reg_req_t   req;
  tspc_pkg::tspc_synth_cfg_t cfg;
  tspc_pkg::tspc_pa_ctrl_t   pa;
  logic [7:0]                rdata, d;
  logic [3:0]                trim;
  logic [2:0]                mode;
  int                        n_errors, num_checks, n;
  tspc_config #(.CAL_CYCLES(CAL)) i_tspc_config (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_reg_req(req), .o_reg_rdata(rdata), .i_synth_locked(i_synth_locked), .o_synth_cfg(cfg),
    .o_bit_tick(tick), .o_cal_running(cal_run), .o_pa_ctrl(pa), .o_ocp_trim(trim),
    .o_mode_current(mode));
  tspc_host i_tspc_host (.i_clk(i_clk), .i_reg_rdata(rdata), .o_reg_req(req));
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  // Counts falling edges while calibration runs; a hang is cut short here
  task automatic count_cal(output int c);
    c = 0;
    while (cal_run === 1'b1 && c < 400) begin
      c++;
      @(negedge i_clk);
    end
    if (c >= 400) begin
      n_errors++;
      tally_and_finish();
    end
  endtask : count_cal
  task automatic t_reset_defaults();
    check("carrier", cfg.carrier_freq_word, 24'he4c000);
    check("rate", cfg.rate_divisor, 16'h1a0b);
    check("trim", trim, 4'ha);
    @(negedge i_clk);
    check("pa", pa, {4'b1001, 6'h0d});
    check("cal_run", cal_run, 1'b1);
    i_tspc_host.read_reg(7'h0a, d);
    check("done_low", d[4], 1'b0);
    count_cal(n);
    i_tspc_host.read_reg(7'h0a, d);
    check("status", d & 8'h1c, 8'h18);
    $display("done reset defaults");
  endtask : t_reset_defaults
  task automatic t_cal_restart();
    i_synth_locked = 1'b0;
    i_tspc_host.write_reg(7'h0a, 8'h04);
    repeat (5) @(negedge i_clk);
    i_tspc_host.write_reg(7'h0a, 8'h04);
    check("cal_run", cal_run, 1'b1);
    count_cal(n);
    check("cal_len", n, CAL);
    i_tspc_host.read_reg(7'h0a, d);
    check("status", d & 8'h1c, 8'h10);
    i_synth_locked = 1'b1;
    $display("done calibration restart");
  endtask : t_cal_restart
  task automatic t_carrier_bands();
    logic [23:0] w[4] = '{24'h4b0000, 24'h708000, 24'he10000, 24'h960000};
    logic [1:0]  b[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    logic [23:0] old;
    for (int k = 0; k < 4; k++) begin
      old = cfg.carrier_freq_word;
      i_tspc_host.write_reg(7'h07, w[k][23:16]);
      i_tspc_host.write_reg(7'h08, w[k][15:8]);
      check("staged", cfg.carrier_freq_word, old);
      i_tspc_host.read_reg(7'h07, d);
      check("high_rd", d, w[k][23:16]);
      i_tspc_host.write_reg(7'h09, w[k][7:0]);
      check("carrier", cfg.carrier_freq_word, w[k]);
      @(negedge i_clk);
      check("band", cfg.band, b[k]);
    end
    $display("done carrier bands");
  endtask : t_carrier_bands
  task automatic t_dev_rate();
    i_tspc_host.write_reg(7'h05, 8'hff);
    i_tspc_host.write_reg(7'h06, 8'ha5);
    check("dev", cfg.deviation_coeff, 14'h3fa5);
    @(negedge i_clk);
    check("lf_dev", cfg.loop_filter_wide, 1'b1);
    i_tspc_host.write_reg(7'h05, 8'h00);
    i_tspc_host.write_reg(7'h06, 8'h52);
    @(negedge i_clk);
    check("lf_off", cfg.loop_filter_wide, 1'b0);
    i_tspc_host.set_rate(16'h0005, 1'b0);
    @(negedge i_clk);
    check("lf_rate", cfg.loop_filter_wide, 1'b1);
    n = 0;
    while (tick !== 1'b1 && n < 20) begin
      n++;
      @(negedge i_clk);
    end
    n = 0;
    do begin
      n++;
      @(negedge i_clk);
    end while (tick !== 1'b1 && n < 20);
    check("tick_gap", n, 5);
    i_tspc_host.set_rate(16'h0010, 1'b1);
    check("rate", cfg.rate_divisor, 16'h03d3);
    $display("done deviation and rate");
  endtask : t_dev_rate
  task automatic t_pa_modes();
    logic [6:0] c[5] = '{7'h2f, 7'h30, 7'h5f, 7'h60, 7'h05};
    logic [9:0] e[5] = '{{4'b1010, 6'h3d}, {4'b1001, 6'h3e}, {4'b0100, 6'h0d},
                         {4'b1101, 6'h33}, 10'h000};
    for (int k = 0; k < 5; k++) begin
      i_tspc_host.write_reg(7'h11, {1'b0, c[k]});
      repeat (2) @(negedge i_clk);
      check("pa", pa, e[k]);
    end
    $display("done amplifier modes");
  endtask : t_pa_modes
  task automatic t_mode_misc();
    logic [2:0] tg[4] = '{3'h3, 3'h0, 3'h2, 3'h1};
    for (int k = 0; k < 4; k++) begin
      i_tspc_host.write_reg(7'h01, {5'h00, tg[k]});
      i_tspc_host.write_reg(7'h01, 8'h05);
      i_tspc_host.read_reg(7'h01, d);
      check("target", d[2:0], tg[k]);
      n = 0;
      while (mode !== tg[k] && n < 8000) begin
        n++;
        @(negedge i_clk);
      end
      check("mode", mode, tg[k]);
    end
    i_tspc_host.set_full_power_trim();
    check("trim", trim, 4'hc);
    i_tspc_host.read_reg(7'h7f, d);
    check("unmapped", d, 8'h00);
    $display("done modes and trim");
  endtask : t_mode_misc
  initial begin
    i_reset_n      = 1'b0;
    i_synth_locked = 1'b1;
    n_errors       = 0;
    num_checks     = 0;
    repeat (4) @(negedge i_clk);
    i_reset_n = 1'b1;
    t_reset_defaults();
    t_cal_restart();
    t_carrier_bands();
    t_dev_rate();
    t_pa_modes();
    t_mode_misc();
    tally_and_finish();
  end
endmodule : tb_top
